// ===== hdl/io_pkg.sv
// shared constants for the jog, teach and status output logic
package io_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int IGNORE_MS = 200;
	localparam int MSG_DELAY_MS = 10;
	localparam logic [23:0] IGNORE_CYCLES = 24'(IGNORE_MS * (CLK_HZ / 1000));
	localparam logic [23:0] MSG_DELAY_CYCLES = 24'(MSG_DELAY_MS * (CLK_HZ / 1000));
	localparam logic [23:0] CNT_MAX = 24'hFFFFFF;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_IGNORE = 8'h04;
	localparam logic [7:0] ADDR_FOLLOW_RANGE = 8'h08;
	localparam logic [7:0] ADDR_FOLLOW_DELAY = 8'h0C;
	localparam logic [7:0] ADDR_TARGET_WIN = 8'h10;
	localparam logic [7:0] ADDR_TARGET_DELAY = 8'h14;
	localparam logic [7:0] ADDR_SPEED_DECL = 8'h18;
	localparam logic [7:0] ADDR_SPEED_WIN = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
	localparam logic [7:0] ADDR_STOP_DECEL = 8'h2C;

	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int CFG_SEL_A_LSB = 0;
	localparam int CFG_SEL_B_LSB = 4;
	localparam int CFG_ENC_BIT = 8;
	localparam logic [8:0] CFG_RESET = 9'h000;
	localparam logic [31:0] FOLLOW_RANGE_RESET = 32'h0000199A;
	localparam logic [31:0] TARGET_WIN_RESET = 32'h000007AE;
	localparam logic [31:0] SPEED_DECL_RESET = 32'h00002710;
	localparam logic [31:0] SPEED_WIN_RESET = 32'h00001388;
	localparam logic [15:0] STOP_DECEL_RESET = 16'h03E8;

	// output function codes
	localparam logic [3:0] SEL_LOW = 4'h0;
	localparam logic [3:0] SEL_HIGH = 4'h1;
	localparam logic [3:0] SEL_POWER = 4'h2;
	localparam logic [3:0] SEL_I2T = 4'h3;
	localparam logic [3:0] SEL_WARN = 4'h4;
	localparam logic [3:0] SEL_ERROR = 4'h5;
	localparam logic [3:0] SEL_FOLLOW = 4'h6;
	localparam logic [3:0] SEL_REMAIN = 4'h7;
	localparam logic [3:0] SEL_TARGET = 4'h8;
	localparam logic [3:0] SEL_HOMED = 4'h9;
	localparam logic [3:0] SEL_COURSE = 4'hA;
	localparam logic [3:0] SEL_SPEED = 4'hB;

	// interrupt bits
	localparam int IRQ_TEACH = 0;
	localparam int IRQ_FOLLOW = 1;
	localparam int IRQ_TARGET = 2;
	localparam int IRQ_STOP = 3;
	localparam int IRQ_ABORT = 4;
	localparam int IRQ_W = 5;

	// discrete input positions
	localparam int IN_LAYOUT = 0;
	localparam int IN_STOP = 1;
	localparam int IN_TEACH = 3;
	localparam int IN_JOGN = 4;
	localparam int IN_JOGP = 5;
	localparam int IN_START = 6;
	localparam int IN_ENABLE = 7;
	localparam int IN_W = 8;

	typedef enum logic [1:0] {
		T_IDLE = 2'b00,
		T_ARMED = 2'b01,
		T_START = 2'b10,
		T_IGNORE = 2'b11
	} teach_state_e;

endpackage

// ===== hdl/io_sync.sv
// two-stage synchroniser with edge detect for the discrete inputs
`timescale 1ns/1ns
module io_sync import io_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// raw pins
	input wire logic [IN_W-1:0] raw,
	// synchronised level and edges
	output logic [IN_W-1:0] level,
	output logic [IN_W-1:0] rise,
	output logic [IN_W-1:0] fall
);

	genvar i;
	generate
		for (i = 0; i < IN_W; i++) begin : g_bit
			logic meta_reg;
			logic sync_reg;
			logic last_reg;
			// first stage feeds only the second
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
					last_reg <= 1'b0;
				end else begin
					meta_reg <= raw[i];
					sync_reg <= meta_reg;
					last_reg <= sync_reg;
				end
			end
			assign level[i] = sync_reg;
			assign rise[i] = sync_reg & ~last_reg;
			assign fall[i] = ~sync_reg & last_reg;
		end
	endgenerate

endmodule

// ===== hdl/jog_teach_io_logic.sv
// discrete input decoding, teach sequencer and status outputs of the drive
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module jog_teach_io_logic import io_pkg::*; #(
	parameter logic [23:0] IGNORE_DEFAULT = IGNORE_CYCLES,
	parameter logic [23:0] MSG_DELAY_DEFAULT = MSG_DELAY_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic irq,
	// discrete inputs
	input wire logic layout_select_in,
	input wire logic stop_n_in,
	input wire logic aux_in,
	input wire logic teach_arm_in,
	input wire logic jog_neg_in,
	input wire logic jog_pos_in,
	input wire logic start_in,
	input wire logic ctrl_enable_in,
	// motion core commands
	output logic pos_start,
	output logic [4:0] pos_number,
	output logic homing_start,
	output logic stop_req,
	output logic [15:0] stop_decel,
	output logic jog_neg,
	output logic jog_pos,
	output logic teach_store,
	output logic [5:0] teach_dest,
	output logic inputs_ignored,
	// drive state
	input wire logic switched_on,
	input wire logic error_active,
	input wire logic power_active,
	input wire logic i2t_active,
	input wire logic warning_active,
	input wire logic remain_active,
	input wire logic homing_done,
	input wire logic course_active,
	input wire logic brake_release,
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic signed [31:0] actual_pos,
	input wire logic signed [31:0] demand_pos,
	input wire logic signed [31:0] target_pos,
	input wire logic signed [31:0] actual_speed,
	// digital outputs
	output logic ready_out,
	output logic config_out_a,
	output logic config_out_b,
	output logic brake_release_out
);

	// ****************************************
	// helpers
	// ****************************************

	// magnitude of a difference, saturated to 32 bits
	function automatic logic [31:0] abs_diff(input logic signed [31:0] a,
		input logic signed [31:0] b);
		logic signed [32:0] d;
		logic [32:0] m;
		d = {a[31], a} - {b[31], b};
		m = d[32] ? 33'(-d) : 33'(d);
		return m[32] ? 32'hFFFFFFFF : m[31:0];
	endfunction

	// function select for a configurable output
	function automatic logic pick(input logic [3:0] sel, input logic [15:0] src);
		return src[sel];
	endfunction

	// ****************************************
	// input synchronisation
	// ****************************************
	logic [IN_W-1:0] raw;
	logic [IN_W-1:0] lvl;
	logic [IN_W-1:0] rise;
	logic [IN_W-1:0] fall;

	assign raw = {ctrl_enable_in, start_in, jog_pos_in, jog_neg_in,
		teach_arm_in, aux_in, stop_n_in, layout_select_in};

	io_sync u_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.raw(raw),
		.level(lvl),
		.rise(rise),
		.fall(fall)
	);

	// ****************************************
	// registers
	// ****************************************
	logic [8:0] cfg_reg;
	logic [23:0] ignore_reg;
	logic [31:0] follow_range_reg;
	logic [23:0] follow_delay_reg;
	logic [31:0] target_win_reg;
	logic [23:0] target_delay_reg;
	logic [31:0] speed_decl_reg;
	logic [31:0] speed_win_reg;
	logic [IRQ_W-1:0] irq_stat_reg;
	logic [IRQ_W-1:0] irq_mask_reg;
	logic [15:0] stop_decel_reg;

	// teach state and message state
	teach_state_e state_reg;
	teach_state_e state_next;
	logic [23:0] ign_cnt_reg;
	logic [1:0] msg_reg;
	logic speed_msg_reg;

	// ****************************************
	// input decoding
	// ****************************************
	logic busy;
	logic live;
	logic ext;
	logic stop_low;
	logic armed;
	logic jog_ok;
	logic abort;

	// during the start phase the layout pin carries a destination bit,
	// so the extended layout is held until the store
	assign busy = (state_reg == T_START);
	assign live = (state_reg != T_IGNORE);
	assign ext = lvl[IN_LAYOUT] | busy;
	assign stop_low = ext & ~busy & ~lvl[IN_STOP];
	assign armed = (state_reg == T_ARMED);
	assign jog_ok = live & ext & ~busy & ~stop_low;
	// losing the enable mid-sequence drops the teach attempt
	assign abort = (armed | busy) & ~lvl[IN_ENABLE];

	logic pos_start_next;
	logic homing_next;
	logic jogn_next;
	logic jogp_next;
	logic store_next;

	assign pos_start_next = live & ~lvl[IN_LAYOUT] & ~busy & rise[IN_START];
	assign homing_next = jog_ok & rise[IN_START] & ~armed & ~stop_low;
	// both jog pins high cancel each other
	assign jogn_next = jog_ok & lvl[IN_JOGN] & ~lvl[IN_JOGP];
	assign jogp_next = jog_ok & lvl[IN_JOGP] & ~lvl[IN_JOGN];
	assign store_next = busy & lvl[IN_ENABLE] & fall[IN_START];

	// ****************************************
	// teach sequencer
	// ****************************************
	logic ign_done;
	assign ign_done = (ign_cnt_reg >= ignore_reg);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			T_IDLE: begin
				if (lvl[IN_LAYOUT] & lvl[IN_TEACH] & lvl[IN_ENABLE]) begin
					state_next = T_ARMED;
				end
			end
			T_ARMED: begin
				if (abort | ~lvl[IN_TEACH] | ~lvl[IN_LAYOUT]) begin
					state_next = T_IDLE;
				end else if (rise[IN_START]) begin
					state_next = T_START;
				end
			end
			T_START: begin
				if (abort) begin
					state_next = T_IDLE;
				end else if (fall[IN_START]) begin
					state_next = T_IGNORE;
				end
			end
			T_IGNORE: begin
				// returns to idle; teach pin still high re-arms directly
				if (ign_done) begin
					state_next = T_IDLE;
				end
			end
			default: begin
				state_next = T_IDLE;
			end
		endcase
	end

	// state and ignore timer
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_reg <= T_IDLE;
			ign_cnt_reg <= 24'h000000;
		end else begin
			state_reg <= state_next;
			ign_cnt_reg <= live ? 24'h000000 : ign_cnt_reg + 24'h000001;
		end
	end

	// registered command outputs
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pos_start <= 1'b0;
			pos_number <= 5'h00;
			homing_start <= 1'b0;
			stop_req <= 1'b0;
			jog_neg <= 1'b0;
			jog_pos <= 1'b0;
			teach_store <= 1'b0;
			teach_dest <= 6'h00;
			inputs_ignored <= 1'b0;
		end else begin
			pos_start <= pos_start_next;
			// position on inputs 1..3, group on inputs 4..5
			pos_number <= pos_start_next ? lvl[5:1] : pos_number;
			homing_start <= homing_next;
			stop_req <= live & stop_low;
			jog_neg <= jogn_next;
			jog_pos <= jogp_next;
			teach_store <= store_next;
			teach_dest <= store_next ? lvl[5:0] : teach_dest;
			inputs_ignored <= (state_next == T_IGNORE);
		end
	end

	assign stop_decel = stop_decel_reg;

	// ****************************************
	// messages
	// ****************************************
	logic [31:0] follow_dev;
	logic [31:0] target_dev;
	logic [31:0] speed_dev;
	logic [1:0] msg_cond;
	logic [23:0] msg_delay [2];

	assign follow_dev = abs_diff(actual_pos, demand_pos);
	assign target_dev = abs_diff(actual_pos, target_pos);
	assign speed_dev = abs_diff(actual_speed, speed_decl_reg);
	assign msg_cond[0] = (follow_dev > follow_range_reg);
	assign msg_cond[1] = (target_dev <= target_win_reg);
	assign msg_delay[0] = follow_delay_reg;
	assign msg_delay[1] = target_delay_reg;

	// one saturating timer per delayed message; a single miss restarts it
	genvar m;
	generate
		for (m = 0; m < 2; m++) begin : g_msg
			logic [23:0] cnt_reg;
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					cnt_reg <= 24'h000000;
					msg_reg[m] <= 1'b0;
				end else begin
					cnt_reg <= ~msg_cond[m] ? 24'h000000 :
						(cnt_reg == CNT_MAX) ? cnt_reg : cnt_reg + 24'h000001;
					msg_reg[m] <= msg_cond[m] & (cnt_reg >= msg_delay[m]);
				end
			end
		end
	endgenerate

	// speed message has no delay
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			speed_msg_reg <= 1'b0;
		end else begin
			speed_msg_reg <= (speed_dev <= speed_win_reg);
		end
	end

	// ****************************************
	// digital outputs
	// ****************************************
	logic [15:0] src;
	logic out_a_next;
	logic out_b_next;

	assign src = {4'h0, speed_msg_reg, course_active, homing_done, msg_reg[1],
		remain_active, msg_reg[0], error_active, warning_active, i2t_active,
		power_active, 1'b1, 1'b0};
	assign out_a_next = cfg_reg[CFG_ENC_BIT] ? enc_a :
		pick(cfg_reg[CFG_SEL_A_LSB +: 4], src);
	assign out_b_next = cfg_reg[CFG_ENC_BIT] ? enc_b :
		pick(cfg_reg[CFG_SEL_B_LSB +: 4], src);

	// output flops; emulated encoder gets one cycle of latency
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ready_out <= 1'b0;
			config_out_a <= 1'b0;
			config_out_b <= 1'b0;
			brake_release_out <= 1'b0;
		end else begin
			ready_out <= switched_on & ~error_active;
			config_out_a <= out_a_next;
			config_out_b <= out_b_next;
			brake_release_out <= brake_release;
		end
	end

	// ****************************************
	// interrupts
	// ****************************************
	logic [1:0] msg_last_reg;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;

	assign irq_set[IRQ_TEACH] = store_next;
	assign irq_set[IRQ_FOLLOW] = msg_reg[0] & ~msg_last_reg[0];
	assign irq_set[IRQ_TARGET] = msg_reg[1] & ~msg_last_reg[1];
	assign irq_set[IRQ_STOP] = live & stop_low & fall[IN_STOP];
	assign irq_set[IRQ_ABORT] = abort;
	assign irq_clr = (wr && addr == ADDR_IRQ_STAT) ? wdata[IRQ_W-1:0] : '0;
	assign irq = |(irq_stat_reg & irq_mask_reg);

	// a set in the clearing cycle survives
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_stat_reg <= '0;
			msg_last_reg <= 2'b00;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
			msg_last_reg <= msg_reg;
		end
	end

	// ****************************************
	// register port
	// ****************************************
	logic [31:0] status_word;
	logic [31:0] rd_mux;

	assign status_word = {18'h00000, teach_dest, stop_req, inputs_ignored, armed, ext,
		speed_msg_reg, msg_reg[1], msg_reg[0], ready_out};
	assign rd_mux =
		(addr == ADDR_CFG) ? {23'h000000, cfg_reg} :
		(addr == ADDR_IGNORE) ? {8'h00, ignore_reg} :
		(addr == ADDR_FOLLOW_RANGE) ? follow_range_reg :
		(addr == ADDR_FOLLOW_DELAY) ? {8'h00, follow_delay_reg} :
		(addr == ADDR_TARGET_WIN) ? target_win_reg :
		(addr == ADDR_TARGET_DELAY) ? {8'h00, target_delay_reg} :
		(addr == ADDR_SPEED_DECL) ? speed_decl_reg :
		(addr == ADDR_SPEED_WIN) ? speed_win_reg :
		(addr == ADDR_STATUS) ? status_word :
		(addr == ADDR_IRQ_STAT) ? {27'h0000000, irq_stat_reg} :
		(addr == ADDR_IRQ_MASK) ? {27'h0000000, irq_mask_reg} :
		(addr == ADDR_STOP_DECEL) ? {16'h0000, stop_decel_reg} : 32'h00000000;

	// read data valid only in the cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdata <= 32'h00000000;
		end else begin
			rdata <= rd ? rd_mux : 32'h00000000;
		end
	end

	// software writes
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cfg_reg <= CFG_RESET;
			ignore_reg <= IGNORE_DEFAULT;
			follow_range_reg <= FOLLOW_RANGE_RESET;
			follow_delay_reg <= MSG_DELAY_DEFAULT;
			target_win_reg <= TARGET_WIN_RESET;
			target_delay_reg <= MSG_DELAY_DEFAULT;
			speed_decl_reg <= SPEED_DECL_RESET;
			speed_win_reg <= SPEED_WIN_RESET;
			irq_mask_reg <= '0;
			stop_decel_reg <= STOP_DECEL_RESET;
		end else if (wr) begin
			case (addr)
				ADDR_CFG: cfg_reg <= wdata[8:0];
				ADDR_IGNORE: ignore_reg <= wdata[23:0];
				ADDR_FOLLOW_RANGE: follow_range_reg <= wdata;
				ADDR_FOLLOW_DELAY: follow_delay_reg <= wdata[23:0];
				ADDR_TARGET_WIN: target_win_reg <= wdata;
				ADDR_TARGET_DELAY: target_delay_reg <= wdata[23:0];
				ADDR_SPEED_DECL: speed_decl_reg <= wdata;
				ADDR_SPEED_WIN: speed_win_reg <= wdata;
				ADDR_IRQ_MASK: irq_mask_reg <= wdata[IRQ_W-1:0];
				ADDR_STOP_DECEL: stop_decel_reg <= wdata[15:0];
				default: ;
			endcase
		end
	end

endmodule

// ===== verification/jog_teach_io_chk.sv
// port assertions for the jog, teach and status output logic
`timescale 1ns/1ns
module jog_teach_io_chk (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// watched inputs
	input wire logic layout_select_in,
	input wire logic stop_n_in,
	input wire logic switched_on,
	input wire logic error_active,
	input wire logic brake_release,
	// watched outputs
	input wire logic pos_start,
	input wire logic homing_start,
	input wire logic stop_req,
	input wire logic jog_neg,
	input wire logic jog_pos,
	input wire logic teach_store,
	input wire logic inputs_ignored,
	input wire logic ready_out,
	input wire logic brake_release_out
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	// ****************************************
	// command outputs
	// ****************************************
	a_stop_blocks_jog: assert property (stop_req |-> !jog_neg && !jog_pos)
		else $error("jog output while stop is requested");
	a_jog_one_way: assert property (!(jog_neg && jog_pos))
		else $error("both jog directions at once");
	a_ignore_quiet: assert property (inputs_ignored |-> !pos_start && !homing_start
		&& !jog_neg && !jog_pos && !stop_req)
		else $error("command issued while inputs ignored");
	a_store_then_ignore: assert property (teach_store |-> ##[0:1] inputs_ignored)
		else $error("store not followed by ignore window");
	a_start_single: assert property (pos_start |=> !pos_start)
		else $error("position start longer than one cycle");
	a_store_single: assert property (teach_store |=> !teach_store)
		else $error("store pulse longer than one cycle");
	a_homing_cause: assert property (homing_start |-> $past(layout_select_in, 3)
		&& $past(stop_n_in, 3))
		else $error("homing start without extended layout and stop released");
	a_pos_cause: assert property (pos_start |-> !$past(layout_select_in, 3))
		else $error("position start in extended layout");

	// ****************************************
	// status outputs
	// ****************************************
	a_ready_on: assert property ((switched_on && !error_active)[*3] |-> ready_out)
		else $error("ready missing while on without error");
	a_ready_off: assert property ((!switched_on || error_active)[*3] |-> !ready_out)
		else $error("ready shown while off or in error");
	a_brake_follow: assert property ($stable(brake_release)[*3] |->
		brake_release_out == brake_release)
		else $error("brake output differs from brake state");
endmodule

bind jog_teach_io_logic jog_teach_io_chk i_jog_teach_io_chk (.ref_clk, .reset,
	.layout_select_in, .stop_n_in, .switched_on, .error_active, .brake_release,
	.pos_start, .homing_start, .stop_req, .jog_neg, .jog_pos, .teach_store,
	.inputs_ignored, .ready_out, .brake_release_out);

// ===== verification/switch_model.sv
// model of the switches or controller driving the discrete inputs
`timescale 1ns/1ns
module switch_model #(
	parameter int HOLD_CYC = 16000,
	parameter int DEST_CYC = 50000
) (
	// clock
	input wire logic ref_clk,
	// layout, stop_n, aux, teach, jog neg, jog pos, start, enable
	output logic [7:0] pins
);
	// stop_n idles high so nothing halts by accident
	initial pins = 8'h02;

	// every step stands its minimum hold before the next change
	task automatic set_pins(input logic [7:0] v);
		@(posedge ref_clk);
		pins <= v;
		repeat (HOLD_CYC) @(posedge ref_clk);
	endtask

	// destination stays put long before start is let go
	task automatic set_dest(input logic [7:0] v);
		@(posedge ref_clk);
		pins <= v;
		repeat (DEST_CYC) @(posedge ref_clk);
	endtask
endmodule

// ===== verification/tb_jog_teach_io_logic.sv
// self-checking bench for the jog, teach and status output logic
`timescale 1ns/1ns
module tb_jog_teach_io_logic import io_pkg::*;;
	typedef struct {logic [31:0] exp; logic [31:0] mask;} rd_note_s;
	logic [15:0] exp_sel;
	logic ref_clk = 1'h0;
	logic reset = 1'h1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic rd_d = 1'h0;
	logic [10:0] st = 11'h0B5;
	logic signed [31:0] actual_pos = 32'h0;
	logic signed [31:0] demand_pos = 32'h0;
	logic signed [31:0] target_pos = 32'h0;
	logic signed [31:0] actual_speed = SPEED_DECL_RESET;
	logic [7:0] pins;
	logic [31:0] rdata;
	logic [31:0] rnd;
	logic irq, pos_start, homing_start, stop_req, jog_neg, jog_pos, teach_store;
	logic inputs_ignored, ready_out, config_out_a, config_out_b, brake_release_out;
	logic [4:0] pos_number;
	logic [5:0] teach_dest;
	logic [15:0] stop_decel;
	rd_note_s note;
	rd_note_s rd_q[$];
	logic [31:0] ev_q[$];
	int mismatches = 0;
	int checked = 0;
	int homings = 0;
	int cycles = 0;

	// ****************************************
	// clock, design and switches
	// ****************************************
	always #50 ref_clk = ~ref_clk;

	// short ignore and message delays keep the run brief
	jog_teach_io_logic #(.IGNORE_DEFAULT(24'h32), .MSG_DELAY_DEFAULT(24'h14))
		i_jog_teach_io_logic (
		.ref_clk, .reset, .addr, .wdata, .wr, .rd, .rdata, .irq,
		.layout_select_in(pins[0]), .stop_n_in(pins[1]), .aux_in(pins[2]),
		.teach_arm_in(pins[3]), .jog_neg_in(pins[4]), .jog_pos_in(pins[5]),
		.start_in(pins[6]), .ctrl_enable_in(pins[7]),
		.pos_start, .pos_number, .homing_start, .stop_req, .stop_decel, .jog_neg, .jog_pos,
		.teach_store, .teach_dest, .inputs_ignored,
		.switched_on(st[0]), .error_active(st[1]), .power_active(st[2]), .i2t_active(st[3]),
		.warning_active(st[4]), .remain_active(st[5]), .homing_done(st[6]),
		.course_active(st[7]), .brake_release(st[8]), .enc_a(st[9]), .enc_b(st[10]),
		.actual_pos, .demand_pos, .target_pos, .actual_speed,
		.ready_out, .config_out_a, .config_out_b, .brake_release_out);

	switch_model #(.HOLD_CYC(16), .DEST_CYC(48)) i_switch_model (.ref_clk, .pins);

	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge ref_clk);
		wr <= 1'h0;
	endtask

	// the expected word is noted now, compared when the data stands
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'h1;
		rd_q.push_back('{e, m});
		@(posedge ref_clk);
		rd <= 1'h0;
	endtask

	task automatic end_of_test;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ****************************************
	// result monitor and watchdog
	// ****************************************
	always @(posedge ref_clk) begin
		rd_d <= rd;
		if (rd_d) begin
			note = rd_q.pop_front();
			check("rdata", rdata & note.mask, note.exp);
		end
		if (pos_start) check("pos_number", {27'h0, pos_number}, ev_q.pop_front());
		if (teach_store) check("teach_dest", {26'h0, teach_dest}, ev_q.pop_front());
		if (homing_start) homings++;
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			end_of_test();
		end
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		void'($urandom(48282));
		repeat (10) @(posedge ref_clk);
		reset <= 1'h0;
		// reset values, unmapped place, random deceleration
		rd_reg(ADDR_CFG, 32'h0, 32'hFFFFFFFF);
		rd_reg(ADDR_STOP_DECEL, {16'h0, STOP_DECEL_RESET}, 32'hFFFFFFFF);
		rd_reg(ADDR_FOLLOW_RANGE, FOLLOW_RANGE_RESET, 32'hFFFFFFFF);
		rd_reg(8'h40, 32'h0, 32'hFFFFFFFF);
		rnd = $urandom;
		wr_reg(ADDR_STOP_DECEL, rnd);
		rd_reg(ADDR_STOP_DECEL, {16'h0, rnd[15:0]}, 32'hFFFFFFFF);
		check("stop_decel", {16'h0, stop_decel}, {16'h0, rnd[15:0]});
		$display("registers done");
		// random drive states; target and speed in window, no following error
		rnd = $urandom;
		st[7:2] <= rnd[5:0];
		exp_sel = {4'h0, 1'h1, rnd[5:4], 1'h1, rnd[3], 2'h0, rnd[2:0], 2'h2};
		// every selection code on both outputs, b mirrored
		for (int c = 0; c < 16; c++) begin
			wr_reg(ADDR_CFG, 32'(c) | 32'((15 - c) << 4));
			repeat (4) @(posedge ref_clk);
			check("out_a", 32'(config_out_a), 32'(exp_sel[c]));
			check("out_b", 32'(config_out_b), 32'(exp_sel[15 - c]));
		end
		// encoder emulation overrides a forced-high selection
		wr_reg(ADDR_CFG, 32'h101);
		for (int e = 0; e < 4; e++) begin
			st[10:9] <= 2'(e);
			repeat (4) @(posedge ref_clk);
			check("enc_out", {30'h0, config_out_b, config_out_a}, 32'(e));
		end
		// error drops ready, brake output tracks its state
		for (int e = 0; e < 2; e++) begin
			st[1] <= 1'(e);
			st[8] <= 1'(e);
			repeat (4) @(posedge ref_clk);
			check("ready_out", 32'(ready_out), 32'(1 - e));
			check("brake_release_out", 32'(brake_release_out), 32'(e));
		end
		st[1] <= 1'h0;
		// switched off drops ready as well
		st[0] <= 1'h0;
		repeat (4) @(posedge ref_clk);
		check("ready_out off", 32'(ready_out), 32'h0);
		st[0] <= 1'h1;
		$display("outputs done");
		// deviation at the range is fine, one count over needs the full delay
		wr_reg(ADDR_IRQ_STAT, 32'h1F);
		rnd = $urandom & 32'h0FFFFFFF;
		demand_pos <= rnd;
		actual_pos <= rnd + FOLLOW_RANGE_RESET;
		target_pos <= rnd + FOLLOW_RANGE_RESET;
		repeat (40) @(posedge ref_clk);
		rd_reg(ADDR_STATUS, 32'h0, 32'h2);
		actual_pos <= rnd + FOLLOW_RANGE_RESET + 1;
		target_pos <= rnd + FOLLOW_RANGE_RESET + 1;
		repeat (15) @(posedge ref_clk);
		rd_reg(ADDR_STATUS, 32'h0, 32'h2);
		repeat (15) @(posedge ref_clk);
		rd_reg(ADDR_STATUS, 32'h2, 32'h2);
		rd_reg(ADDR_IRQ_STAT, 32'h2, 32'h2);
		check("irq masked", 32'(irq), 32'h0);
		wr_reg(ADDR_IRQ_MASK, 32'h2);
		@(posedge ref_clk);
		check("irq", 32'(irq), 32'h1);
		wr_reg(ADDR_IRQ_STAT, 32'h2);
		@(posedge ref_clk);
		check("irq cleared", 32'(irq), 32'h0);
		demand_pos <= rnd + FOLLOW_RANGE_RESET + 1;
		// speed 1 to 65536 counts above the window, then on its lower edge
		rnd = $urandom & 32'hFFFF;
		actual_speed <= SPEED_DECL_RESET + SPEED_WIN_RESET + 32'h1 + rnd;
		repeat (3) @(posedge ref_clk);
		rd_reg(ADDR_STATUS, 32'h0, 32'h8);
		actual_speed <= SPEED_DECL_RESET - SPEED_WIN_RESET;
		repeat (3) @(posedge ref_clk);
		rd_reg(ADDR_STATUS, 32'h8, 32'h8);
		$display("messages done");
		// normal layout: start rise launches the selected position
		ev_q.push_back(32'h17);
		i_switch_model.set_pins(8'hAE);
		i_switch_model.set_pins(8'hEE);
		i_switch_model.set_pins(8'hAE);
		check("pending", 32'(ev_q.size()), 32'h0);
		// extended layout: jogging, stop priority, homing start
		i_switch_model.set_pins(8'h93);
		check("jog_neg", 32'(jog_neg), 32'h1);
		i_switch_model.set_pins(8'hA1);
		check("jog_pos stopped", 32'(jog_pos), 32'h0);
		check("stop_req", 32'(stop_req), 32'h1);
		i_switch_model.set_pins(8'hA3);
		check("jog_pos", 32'(jog_pos), 32'h1);
		i_switch_model.set_pins(8'h83);
		i_switch_model.set_pins(8'hC3);
		check("homings", 32'(homings), 32'h1);
		i_switch_model.set_pins(8'h83);
		$display("jog done");
		// teach: arm, start, destination, release, then ignore window
		ev_q.push_back(32'h2B);
		i_switch_model.set_pins(8'h8B);
		i_switch_model.set_pins(8'hCB);
		i_switch_model.set_dest(8'hEB);
		i_switch_model.set_pins(8'hAB);
		repeat (24) @(posedge ref_clk);
		check("inputs_ignored", 32'(inputs_ignored), 32'h1);
		check("homings", 32'(homings), 32'h1);
		repeat (30) @(posedge ref_clk);
		check("inputs_ignored", 32'(inputs_ignored), 32'h0);
		check("pending", 32'(ev_q.size()), 32'h0);
		// teach re-armed; losing the enable aborts and flags it
		i_switch_model.set_pins(8'h2B);
		rd_reg(ADDR_IRQ_STAT, 32'h11, 32'h11);
		$display("teach done");
		i_switch_model.set_pins(8'h02);
		end_of_test();
	end
endmodule
